// File: include/cssq_pkg.sv
package cssq_pkg;
   // Register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   // Register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_CSWORD = 4'h3;
   localparam logic [3:0] REG_BACKUP = 4'h4;
   localparam logic [3:0] REG_FLAGS = 4'h5;
   // CTRL fields
   localparam int CTRL_AUTO_RUN = 0;
   localparam int CTRL_INIT_MW = 1;
   localparam int CTRL_RS_EN = 2;
   localparam logic [2:0] CTRL_RESET = 3'h2;
   // CMD fields (write only, self clearing)
   localparam int CMD_RUN = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_INIT = 2;
   localparam int CMD_COLD = 3;
   // STATUS fields
   localparam int ST_RUN = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_CSF = 2;
   localparam int ST_FRC = 3;
   localparam int ST_ERR = 4;
   localparam int ST_RECENT_PD = 5;
   localparam int ST_OUT_LSB = 6;
   localparam int ST_TASKS = 8;
   // FLAGS fields
   localparam int FLAG_CSF = 0;
   // Backup status word: valid flash backup bit
   localparam int BKP_VALID = 0;
   // Timing
   localparam longint CLK_HZ = 20000000;
   localparam longint RECENT_PD_MS = 500;
   localparam longint RECENT_PD_CYC = RECENT_PD_MS * CLK_HZ / 1000;
   localparam logic [DATA_W-1:0] CSWORD_ALL = 16'hffff;
   localparam logic [DATA_W-1:0] CSWORD_NONE = 16'h0000;
   // Start causes
   typedef enum logic [2:0] {
      CSSQ_C_NONE, CSSQ_C_DOWNLOAD, CSSQ_C_POWER, CSSQ_C_ERRRST,
      CSSQ_C_RESET, CSSQ_C_DIFFERS, CSSQ_C_SIM
   } cssq_cause_t;
   // Output behaviour
   typedef enum logic [1:0] {
      CSSQ_O_TASK, CSSQ_O_FALLBACK, CSSQ_O_ZERO
   } cssq_out_t;
endpackage

// File: rtl/cssq_data_init.sv
`timescale 1ns/100ps
module cssq_data_init #(
   parameter int WORDS = 256,
   parameter int AW = 8,
   parameter int DW = 16
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Control
   input wire logic start_i,
   input wire logic restore_i,
   input wire logic [AW:0] backup_count_i,
   output logic done_o,
   // Word store
   output logic [AW-1:0] mem_addr_o,
   output logic [DW-1:0] mem_wdata_o,
   output logic mem_we_o,
   input wire logic [DW-1:0] init_value_i,
   input wire logic [DW-1:0] backup_value_i
);
   logic busy_q, busy_d;
   logic restore_q, restore_d;
   logic [AW-1:0] idx_q, idx_d;
   logic [DW-1:0] wdata_q, wdata_d;
   logic we_q, we_d;
   logic [AW-1:0] addr_q, addr_d;
   logic last_w;
   logic beyond_w;

   assign last_w = ({1'b0, idx_q} == (AW+1)'(WORDS - 1));
   assign beyond_w = ({1'b0, idx_q} >= backup_count_i);

   // Restore takes the backup copy, words past the backup read zero
   // One address port: a word is looked up, then written a cycle later
   always_comb begin
      busy_d = busy_q;
      restore_d = restore_q;
      idx_d = idx_q;
      we_d = 1'b0;
      addr_d = addr_q;
      wdata_d = wdata_q;
      if (start_i && !busy_q) begin
         busy_d = 1'b1;
         restore_d = restore_i;
         idx_d = '0;
      end else if (busy_q && !we_q) begin
         we_d = 1'b1;
         addr_d = idx_q;
         if (!restore_q) begin
            wdata_d = init_value_i;
         end else if (beyond_w) begin
            wdata_d = '0;
         end else begin
            wdata_d = backup_value_i;
         end
         idx_d = idx_q + 1'b1;
         if (last_w) begin
            busy_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         busy_q <= 1'b0;
         restore_q <= 1'b0;
         idx_q <= '0;
         we_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
      end else begin
         busy_q <= busy_d;
         restore_q <= restore_d;
         idx_q <= idx_d;
         we_q <= we_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
      end
   end

   assign mem_addr_o = (we_q) ? addr_q : idx_q;
   assign mem_wdata_o = wdata_q;
   assign mem_we_o = we_q;
   assign done_o = we_q && !busy_q;
endmodule

// File: rtl/cssq_top.sv
`timescale 1ns/100ps
module cssq_top #(
   parameter int WORDS = 256,
   parameter int MW_AW = 8,
   parameter int FALLBACK_CYC = 16,
   parameter longint RECENT_PD_CYC = cssq_pkg::RECENT_PD_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [cssq_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [cssq_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [cssq_pkg::DATA_W-1:0] reg_rdata_o,
   // Pins
   input wire logic reset_button_i,
   input wire logic power_fail_i,
   input wire logic run_stop_input_i,
   // System events
   input wire logic download_done_i,
   input wire logic app_differs_i,
   input wire logic power_restored_i,
   input wire logic context_lost_i,
   input wire logic init_request_i,
   input wire logic cpu_error_i,
   input wire logic watchdog_halt_i,
   input wire logic master_cycle_end_i,
   input wire logic output_update_i,
   input wire logic [cssq_pkg::DATA_W-1:0] backup_status_word_i,
   input wire logic [MW_AW:0] backup_count_i,
   // Memory words store
   output logic [MW_AW-1:0] mem_addr_o,
   output logic [cssq_pkg::DATA_W-1:0] mem_wdata_o,
   output logic mem_we_o,
   input wire logic [cssq_pkg::DATA_W-1:0] init_value_i,
   input wire logic [cssq_pkg::DATA_W-1:0] backup_value_i,
   // Task control and flags
   output logic run_o,
   output logic master_task_en_o,
   output logic fast_task_en_o,
   output logic auxiliary_task_en_o,
   output logic event_task_en_o,
   output logic cold_start_flag_o,
   output logic first_run_cycle_flag_o,
   output logic [cssq_pkg::DATA_W-1:0] cold_start_status_word_o,
   // Initialization strobes
   output logic init_bits_io_o,
   output logic reset_fb_o,
   output logic reset_dfb_o,
   output logic reset_system_o,
   output logic reset_charts_o,
   output logic cancel_forcing_o,
   output logic clear_queues_o,
   output logic send_config_o,
   // Output behaviour
   output logic [1:0] output_mode_o
);
   typedef enum logic [2:0] {
      CSSQ_IDLE, CSSQ_SELECT, CSSQ_INIT, CSSQ_FIRST, CSSQ_NORMAL, CSSQ_DOWN
   } cssq_state_t;

   localparam int PDW = $clog2(RECENT_PD_CYC + 1);
   localparam int FBW = $clog2(FALLBACK_CYC + 1);

   // Pin synchronisers
   logic [1:0] btn_s_q, pf_s_q, rs_s_q;
   logic btn_q, pf_q, rs_q;
   logic btn_rise_w, pf_rise_w, rs_rise_w;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         btn_s_q <= 2'h0;
         pf_s_q <= 2'h0;
         rs_s_q <= 2'h0;
         btn_q <= 1'b0;
         pf_q <= 1'b0;
         rs_q <= 1'b0;
      end else begin
         btn_s_q <= {btn_s_q[0], reset_button_i};
         pf_s_q <= {pf_s_q[0], power_fail_i};
         rs_s_q <= {rs_s_q[0], run_stop_input_i};
         btn_q <= btn_s_q[1];
         pf_q <= pf_s_q[1];
         rs_q <= rs_s_q[1];
      end
   end

   assign btn_rise_w = btn_s_q[1] && !btn_q;
   assign pf_rise_w = pf_s_q[1] && !pf_q;
   assign rs_rise_w = rs_s_q[1] && !rs_q;

   // Register decode
   logic [2:0] ctrl_q, ctrl_d;
   logic wr_ctrl_w, wr_cmd_w, wr_flags_w;
   logic auto_run_w, init_mw_w, rs_en_w;
   logic cmd_run_w, cmd_stop_w, cmd_init_w, cmd_cold_w, flag_clr_w;

   assign wr_ctrl_w = reg_wr_i && (reg_addr_i == cssq_pkg::REG_CTRL);
   assign wr_cmd_w = reg_wr_i && (reg_addr_i == cssq_pkg::REG_CMD);
   assign wr_flags_w = reg_wr_i && (reg_addr_i == cssq_pkg::REG_FLAGS);
   assign auto_run_w = ctrl_q[cssq_pkg::CTRL_AUTO_RUN];
   assign init_mw_w = ctrl_q[cssq_pkg::CTRL_INIT_MW];
   assign rs_en_w = ctrl_q[cssq_pkg::CTRL_RS_EN];
   assign cmd_run_w = wr_cmd_w && reg_wdata_i[cssq_pkg::CMD_RUN];
   assign cmd_stop_w = wr_cmd_w && reg_wdata_i[cssq_pkg::CMD_STOP];
   assign cmd_init_w = wr_cmd_w && reg_wdata_i[cssq_pkg::CMD_INIT];
   assign cmd_cold_w = wr_cmd_w && reg_wdata_i[cssq_pkg::CMD_COLD];
   // Writing zero to the flag while it is set asks for a simulated start
   assign flag_clr_w = wr_flags_w && !reg_wdata_i[cssq_pkg::FLAG_CSF];
   assign ctrl_d = wr_ctrl_w ? reg_wdata_i[2:0] : ctrl_q;

   // Sequencer state
   cssq_state_t state_q, state_d;
   cssq_pkg::cssq_cause_t cause_q, cause_d, new_cause_w;
   logic run_q, run_d;
   logic err_q, err_d;
   logic csf_q, csf_d;
   logic frc_q, frc_d;
   logic [cssq_pkg::DATA_W-1:0] csw_q, csw_d;
   logic [PDW-1:0] pd_cnt_q, pd_cnt_d;
   logic [FBW-1:0] fb_cnt_q, fb_cnt_d;
   cssq_pkg::cssq_out_t out_q, out_d;
   logic init_go_q, init_go_d;
   logic init_done_w;
   logic restore_w;
   logic recent_pd_w;
   logic stop_w, start_w;
   logic sel_run_w;
   logic accept_w;

   assign recent_pd_w = (pd_cnt_q != '0);
   assign accept_w = (state_q == CSSQ_IDLE) || (state_q == CSSQ_NORMAL);

   // Cause arbitration; a press soon after an outage is still a cold start
   always_comb begin
      new_cause_w = cssq_pkg::CSSQ_C_NONE;
      if (download_done_i) begin
         new_cause_w = cssq_pkg::CSSQ_C_DOWNLOAD;
      end else if (btn_rise_w && err_q) begin
         new_cause_w = cssq_pkg::CSSQ_C_ERRRST;
      end else if (btn_rise_w) begin
         new_cause_w = cssq_pkg::CSSQ_C_RESET;
      end else if (app_differs_i) begin
         new_cause_w = cssq_pkg::CSSQ_C_DIFFERS;
      end else if (init_request_i || cmd_init_w || cmd_cold_w ||
                   (flag_clr_w && csf_q)) begin
         new_cause_w = cssq_pkg::CSSQ_C_SIM;
      end
   end

   // Stop wins over run, wherever it comes from
   assign stop_w = cmd_stop_w || (rs_en_w && !rs_q);
   assign start_w = cmd_run_w || (rs_en_w && rs_rise_w);

   // Resulting state of a cold start
   always_comb begin
      case (cause_q)
         cssq_pkg::CSSQ_C_DOWNLOAD: sel_run_w = 1'b0;
         cssq_pkg::CSSQ_C_ERRRST: sel_run_w = 1'b0;
         cssq_pkg::CSSQ_C_SIM: sel_run_w = run_q;
         default: sel_run_w = auto_run_w || (rs_en_w && rs_q);
      endcase
   end

   // A reset press never restores the retained words
   assign restore_w = !init_mw_w &&
                      backup_status_word_i[cssq_pkg::BKP_VALID] &&
                      (cause_q != cssq_pkg::CSSQ_C_RESET) &&
                      (cause_q != cssq_pkg::CSSQ_C_ERRRST);

   always_comb begin
      state_d = state_q;
      cause_d = cause_q;
      run_d = run_q;
      csf_d = csf_q;
      frc_d = frc_q;
      csw_d = csw_q;
      init_go_d = 1'b0;
      err_d = err_q;
      case (state_q)
         CSSQ_IDLE, CSSQ_NORMAL: begin
            if (stop_w) begin
               run_d = 1'b0;
            end else if (start_w) begin
               run_d = 1'b1;
            end
            if (new_cause_w != cssq_pkg::CSSQ_C_NONE) begin
               cause_d = new_cause_w;
               state_d = CSSQ_SELECT;
            end
         end
         CSSQ_SELECT: begin
            run_d = sel_run_w && !stop_w;
            init_go_d = 1'b1;
            state_d = CSSQ_INIT;
         end
         CSSQ_INIT: begin
            if (stop_w) begin
               run_d = 1'b0;
            end
            if (init_done_w) begin
               csw_d = cssq_pkg::CSWORD_NONE;
               state_d = CSSQ_FIRST;
            end
         end
         CSSQ_FIRST: begin
            if (stop_w) begin
               run_d = 1'b0;
            end else if (start_w) begin
               run_d = 1'b1;
            end
            // In STOP the flags only rise once a later start arrives
            csf_d = run_q;
            frc_d = run_q;
            if (run_q && master_cycle_end_i) begin
               csf_d = 1'b0;
               frc_d = 1'b0;
               csw_d = cssq_pkg::CSWORD_ALL;
               state_d = CSSQ_NORMAL;
            end
         end
         CSSQ_DOWN: begin
            if (power_restored_i && context_lost_i) begin
               cause_d = cssq_pkg::CSSQ_C_POWER;
               state_d = CSSQ_SELECT;
            end else if (power_restored_i) begin
               state_d = CSSQ_IDLE;
            end
         end
         default: state_d = CSSQ_IDLE;
      endcase
      if (state_q == CSSQ_SELECT) begin
         err_d = 1'b0;
      end
      if (cpu_error_i && !watchdog_halt_i) begin
         err_d = 1'b1;
      end else if (watchdog_halt_i) begin
         err_d = 1'b0;
      end
      if (pf_rise_w) begin
         state_d = CSSQ_DOWN;
         run_d = 1'b0;
      end
   end

   // Recent outage window and output behaviour
   always_comb begin
      pd_cnt_d = pd_cnt_q;
      fb_cnt_d = fb_cnt_q;
      out_d = out_q;
      if (pf_rise_w) begin
         pd_cnt_d = PDW'(RECENT_PD_CYC);
      end else if (recent_pd_w) begin
         pd_cnt_d = pd_cnt_q - 1'b1;
      end
      if (pf_rise_w) begin
         out_d = cssq_pkg::CSSQ_O_FALLBACK;
         fb_cnt_d = FBW'(FALLBACK_CYC);
      end else if (out_q == cssq_pkg::CSSQ_O_FALLBACK) begin
         if (fb_cnt_q != '0) begin
            fb_cnt_d = fb_cnt_q - 1'b1;
         end else begin
            out_d = cssq_pkg::CSSQ_O_ZERO;
         end
      end else if ((out_q == cssq_pkg::CSSQ_O_ZERO) &&
                   (state_q != CSSQ_DOWN) && output_update_i) begin
         out_d = cssq_pkg::CSSQ_O_TASK;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctrl_q <= cssq_pkg::CTRL_RESET;
         state_q <= CSSQ_IDLE;
         cause_q <= cssq_pkg::CSSQ_C_NONE;
         run_q <= 1'b0;
         err_q <= 1'b0;
         csf_q <= 1'b0;
         frc_q <= 1'b0;
         csw_q <= cssq_pkg::CSWORD_NONE;
         pd_cnt_q <= '0;
         fb_cnt_q <= '0;
         out_q <= cssq_pkg::CSSQ_O_ZERO;
         init_go_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         state_q <= state_d;
         cause_q <= cause_d;
         run_q <= run_d;
         err_q <= err_d;
         csf_q <= csf_d;
         frc_q <= frc_d;
         csw_q <= csw_d;
         pd_cnt_q <= pd_cnt_d;
         fb_cnt_q <= fb_cnt_d;
         out_q <= out_d;
         init_go_q <= init_go_d;
      end
   end

   // Word initializer; every cold start walks the whole word store
   cssq_data_init #(
      .WORDS(WORDS),
      .AW(MW_AW),
      .DW(cssq_pkg::DATA_W)
   ) u_init (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .start_i(init_go_q),
      .restore_i(restore_w),
      .backup_count_i(backup_count_i),
      .done_o(init_done_w),
      .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o),
      .mem_we_o(mem_we_o),
      .init_value_i(init_value_i),
      .backup_value_i(backup_value_i)
   );

   // Side strobes fire together with the start of the word walk
   assign init_bits_io_o = init_go_q;
   assign reset_fb_o = init_go_q;
   assign reset_dfb_o = init_go_q;
   assign reset_system_o = init_go_q;
   assign reset_charts_o = init_go_q;
   assign cancel_forcing_o = init_go_q;
   assign clear_queues_o = init_go_q;
   assign send_config_o = init_go_q;

   // Tasks
   assign run_o = run_q;
   assign master_task_en_o = run_q &&
      ((state_q == CSSQ_FIRST) || (state_q == CSSQ_NORMAL) ||
       (state_q == CSSQ_IDLE)) || (state_q == CSSQ_INIT);
   assign fast_task_en_o = run_q && (state_q == CSSQ_NORMAL);
   assign auxiliary_task_en_o = run_q && (state_q == CSSQ_NORMAL);
   assign event_task_en_o = run_q && (state_q == CSSQ_NORMAL);
   assign cold_start_flag_o = csf_q;
   assign first_run_cycle_flag_o = frc_q;
   assign cold_start_status_word_o = csw_q;
   assign output_mode_o = out_q;

   // Read port, one cycle latency; unmapped reads give zero
   logic [cssq_pkg::DATA_W-1:0] rdata_q, rmux_w, status_w;

   assign status_w = {
      7'h00,
      (state_q == CSSQ_NORMAL),
      out_q,
      recent_pd_w,
      err_q,
      frc_q,
      csf_q,
      !accept_w,
      run_q
   };

   always_comb begin
      case (reg_addr_i)
         cssq_pkg::REG_CTRL: rmux_w = {13'h0000, ctrl_q};
         cssq_pkg::REG_STATUS: rmux_w = status_w;
         cssq_pkg::REG_CSWORD: rmux_w = csw_q;
         cssq_pkg::REG_BACKUP: rmux_w = backup_status_word_i;
         cssq_pkg::REG_FLAGS: rmux_w = {15'h0000, csf_q};
         default: rmux_w = '0;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= reg_rd_i ? rmux_w : '0;
      end
   end

   assign reg_rdata_o = rdata_q;
endmodule

// File: tb/cssq_asserts.sv
`timescale 1ns/100ps
module cssq_asserts (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Inputs that cause behaviour
   input wire logic [cssq_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [cssq_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic master_cycle_end_i,
   input wire logic output_update_i,
   // Sequencer outputs
   input wire logic mem_we_o,
   input wire logic run_o,
   input wire logic master_task_en_o,
   input wire logic fast_task_en_o,
   input wire logic auxiliary_task_en_o,
   input wire logic event_task_en_o,
   input wire logic cold_start_flag_o,
   input wire logic first_run_cycle_flag_o,
   input wire logic [cssq_pkg::DATA_W-1:0] cold_start_status_word_o,
   input wire logic init_bits_io_o,
   input wire logic reset_fb_o,
   input wire logic reset_dfb_o,
   input wire logic reset_system_o,
   input wire logic reset_charts_o,
   input wire logic cancel_forcing_o,
   input wire logic clear_queues_o,
   input wire logic send_config_o,
   input wire logic [1:0] output_mode_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence init_burst;
      init_bits_io_o && reset_fb_o && reset_dfb_o && reset_system_o &&
      reset_charts_o && cancel_forcing_o && clear_queues_o && send_config_o;
   endsequence
   sequence first_end;
      first_run_cycle_flag_o && master_cycle_end_i;
   endsequence
   sequence fallback_then_zero;
      (output_mode_o == 2'h1) [*8] ##[1:30] (output_mode_o == 2'h2);
   endsequence
   sequence stop_cmd;
      reg_wr_i && reg_addr_i == cssq_pkg::REG_CMD &&
      reg_wdata_i[cssq_pkg::CMD_STOP];
   endsequence
   init_strobes_a: assert property (init_bits_io_o |->
      init_burst ##[1:4] mem_we_o)
      else $error("init strobes not issued together");
   phase_order_a: assert property (init_burst |=> (!init_bits_io_o) [*8])
      else $error("second init burst during data init");
   init_tasks_a: assert property (mem_we_o |-> master_task_en_o &&
      !fast_task_en_o && !auxiliary_task_en_o && !event_task_en_o)
      else $error("task enables wrong during data init");
   secondary_same_a: assert property (fast_task_en_o == event_task_en_o &&
      fast_task_en_o == auxiliary_task_en_o &&
      (!fast_task_en_o || cold_start_status_word_o == 16'hffff))
      else $error("secondary task enables differ");
   first_flags_a: assert property (first_run_cycle_flag_o |-> run_o &&
      cold_start_flag_o && cold_start_status_word_o == 16'h0000)
      else $error("first cycle flags or word wrong");
   cycle_end_a: assert property (first_end |=> !cold_start_flag_o &&
      !first_run_cycle_flag_o && cold_start_status_word_o == 16'hffff &&
      fast_task_en_o)
      else $error("end of first cycle not applied");
   stop_wins_a: assert property (stop_cmd |-> ##[1:3] !run_o)
      else $error("stop command did not stop");
   fallback_seq_a: assert property ($rose(output_mode_o == 2'h1) |->
      fallback_then_zero)
      else $error("fallback then zero output order broken");
   zero_hold_a: assert property (output_mode_o == 2'h2 &&
      !output_update_i |=> output_mode_o != 2'h0)
      else $error("outputs left zero without task update");
endmodule
bind cssq_top cssq_asserts u_chk (.clock_i, .rst_n_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .master_cycle_end_i, .output_update_i, .mem_we_o,
   .run_o, .master_task_en_o, .fast_task_en_o, .auxiliary_task_en_o,
   .event_task_en_o, .cold_start_flag_o, .first_run_cycle_flag_o,
   .cold_start_status_word_o, .init_bits_io_o, .reset_fb_o, .reset_dfb_o,
   .reset_system_o, .reset_charts_o, .cancel_forcing_o, .clear_queues_o,
   .send_config_o, .output_mode_o);

// File: tb/cssq_far.sv
`timescale 1ns/100ps
module cssq_far (
   // Clock
   input wire logic clock_i,
   // Requests from the bench
   input wire logic press_i,
   input wire logic [15:0] salt_i,
   // Button pin and word store lookups
   output logic reset_button_o,
   input wire logic [3:0] mem_addr_i,
   output logic [15:0] init_value_o,
   output logic [15:0] backup_value_o
);
   int hold = 0;
   // A press is held long enough to pass the pin synchronizer
   always @(posedge clock_i) begin
      if (press_i)
         hold <= 6;
      else if (hold > 0)
         hold <= hold - 1;
   end
   assign reset_button_o = hold > 0;
   // Lookups are combinational on the shared address port, as the store would be
   assign init_value_o = ({12'h000, mem_addr_i} * 16'h0003) ^ salt_i;
   assign backup_value_o = ~init_value_o;
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
   $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module tb;
   localparam int DL = 0, AD = 1, PR = 2, IR = 3, CE = 4, ME = 6, OU = 7;
   logic clock_i, rst_n_i, reg_wr_i, reg_rd_i, reset_button_i, press;
   logic power_fail_i, run_stop_input_i, context_lost_i;
   logic [3:0] reg_addr_i, mem_addr_o;
   logic [15:0] reg_wdata_i, reg_rdata_o, backup_status_word_i, salt;
   logic [15:0] mem_wdata_o, init_value_i, backup_value_i;
   logic [15:0] cold_start_status_word_o;
   logic [4:0] backup_count_i;
   logic [1:0] output_mode_o;
   logic download_done_i, app_differs_i, power_restored_i, init_request_i;
   logic cpu_error_i, watchdog_halt_i, master_cycle_end_i, output_update_i;
   logic mem_we_o, run_o, master_task_en_o, fast_task_en_o;
   logic auxiliary_task_en_o, event_task_en_o, cold_start_flag_o;
   logic first_run_cycle_flag_o, init_bits_io_o, reset_fb_o, reset_dfb_o;
   logic reset_system_o, reset_charts_o, cancel_forcing_o, clear_queues_o;
   logic send_config_o;
   logic [7:0] ev;
   logic [15:0] got [16];
   int nwr, err_total, tests_run;
   assign {output_update_i, master_cycle_end_i, watchdog_halt_i, cpu_error_i,
      init_request_i, power_restored_i, app_differs_i, download_done_i} = ev;
   // Small recent-outage window keeps the run short
   cssq_top #(.WORDS(16), .MW_AW(4), .RECENT_PD_CYC(200)) dut (.clock_i,
      .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .reset_button_i, .power_fail_i, .run_stop_input_i, .download_done_i,
      .app_differs_i, .power_restored_i, .context_lost_i, .init_request_i,
      .cpu_error_i, .watchdog_halt_i, .master_cycle_end_i, .output_update_i,
      .backup_status_word_i, .backup_count_i, .mem_addr_o, .mem_wdata_o,
      .mem_we_o, .init_value_i, .backup_value_i, .run_o, .master_task_en_o,
      .fast_task_en_o, .auxiliary_task_en_o, .event_task_en_o,
      .cold_start_flag_o, .first_run_cycle_flag_o, .cold_start_status_word_o,
      .init_bits_io_o, .reset_fb_o, .reset_dfb_o, .reset_system_o,
      .reset_charts_o, .cancel_forcing_o, .clear_queues_o, .send_config_o,
      .output_mode_o);
   cssq_far u_far (.clock_i, .press_i(press), .salt_i(salt),
      .reset_button_o(reset_button_i), .mem_addr_i(mem_addr_o),
      .init_value_o(init_value_i), .backup_value_o(backup_value_i));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      if (mem_we_o === 1'b1) begin
         got[mem_addr_o] <= mem_wdata_o;
         nwr <= nwr + 1;
      end
   end
   // Model of one stored word after a start
   function automatic logic [15:0] exp_w(int i, bit rs);
      logic [15:0] v;
      v = 16'(i * 3) ^ salt;
      if (!rs)
         return v;
      return (i < int'(backup_count_i)) ? ~v : 16'h0000;
   endfunction
   task finish_test();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task stop_hung();
      err_total++;
      finish_test();
   endtask
   task pulse(input int b);
      ev <= 8'h01 << b;
      @(posedge clock_i);
      ev <= 8'h00;
      @(posedge clock_i);
   endtask
   task start(input int b);
      nwr = 0;
      if (b < 0) begin
         press <= 1'b1;
         @(posedge clock_i);
         press <= 1'b0;
         @(posedge clock_i);
      end else
         pulse(b);
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      @(negedge clock_i);
      `CHK(reg_rdata_o, e)
      @(posedge clock_i);
   endtask
   task first_cycle();
      int n;
      n = 0;
      if (run_o !== 1'b1)
         wr(cssq_pkg::REG_CMD, 16'h0001);
      while (first_run_cycle_flag_o !== 1'b1 && n < 50) begin
         @(negedge clock_i);
         n++;
      end
      if (n == 50)
         stop_hung();
      `CHK(cold_start_status_word_o, 16'h0000)
      `CHK(event_task_en_o, 1'b0)
      @(posedge clock_i);
      pulse(ME);
      @(negedge clock_i);
      `CHK(cold_start_flag_o, 1'b0)
      `CHK(cold_start_status_word_o[0], 1'b1)
      `CHK(auxiliary_task_en_o, 1'b1)
      @(posedge clock_i);
   endtask
   task seq_check(input bit rs, input logic er);
      int n;
      n = 0;
      while (nwr < 16 && n < 400) begin
         @(negedge clock_i);
         n++;
      end
      if (n == 400)
         stop_hung();
      repeat (3) @(negedge clock_i);
      for (int i = 0; i < 16; i++) `CHK(got[i], exp_w(i, rs))
      `CHK(nwr, 16)
      `CHK(run_o, er)
      if (!er) `CHK(cold_start_flag_o, 1'b0)
      @(posedge clock_i);
      first_cycle();
   endtask
   task outage(input logic lost);
      power_fail_i <= 1'b1;
      repeat (6) @(negedge clock_i);
      `CHK(output_mode_o, 2'h1)
      repeat (30) @(negedge clock_i);
      `CHK(output_mode_o, 2'h2)
      @(posedge clock_i);
      power_fail_i <= 1'b0;
      context_lost_i <= lost;
      start(PR);
   endtask
   initial begin
      salt = 16'($urandom(32'h289e));
      {rst_n_i, reg_wr_i, reg_rd_i, press, power_fail_i} = 5'h00;
      {run_stop_input_i, context_lost_i, ev, reg_addr_i} = 14'h0000;
      {reg_wdata_i, backup_status_word_i, backup_count_i} = 37'h1_0000;
      {nwr, err_total, tests_run} = 96'h0;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      rd(cssq_pkg::REG_CTRL, 16'h0002);
      wr(cssq_pkg::REG_CSWORD, 16'h1234);
      rd(cssq_pkg::REG_CSWORD, 16'h0000);
      rd(4'hf, 16'h0000);
      rd(cssq_pkg::REG_BACKUP, 16'h0800);
      wr(cssq_pkg::REG_CTRL, 16'h0003);
      start(DL);
      seq_check(1'b0, 1'b0);
      wr(cssq_pkg::REG_CTRL, 16'h0001);
      start(-1);
      seq_check(1'b0, 1'b1);
      pulse(CE);
      start(-1);
      seq_check(1'b0, 1'b0);
      run_stop_input_i <= 1'b1;
      wr(cssq_pkg::REG_CTRL, 16'h0004);
      start(AD);
      seq_check(1'b0, 1'b1);
      wr(cssq_pkg::REG_CTRL, 16'h0000);
      wr(cssq_pkg::REG_CMD, 16'h0003);
      repeat (3) @(negedge clock_i);
      `CHK(run_o, 1'b0)
      @(posedge clock_i);
      // Three ways of asking for an application-only init
      for (int k = 0; k < 3; k++) begin
         nwr = 0;
         if (k == 0)
            pulse(IR);
         else
            wr(cssq_pkg::REG_CMD, 16'h0002 << k);
         seq_check(1'b0, k != 0);
      end
      // Outages: lost context with and without retention, then a press inside the recent-outage window
      for (int k = 0; k < 4; k++) begin
         salt <= 16'($urandom);
         backup_count_i <= 5'($urandom_range(16));
         backup_status_word_i <= {15'($urandom), 1'(4'b1011 >> k)};
         wr(cssq_pkg::REG_CTRL, k[0] ? {14'h0, k != 3, 1'b1} : 16'h0000);
         outage(k != 3);
         if (k == 3) begin
            rd(cssq_pkg::REG_STATUS, 16'h00a0);
            start(-1);
         end
         seq_check(k == 0, k[0]);
         `CHK(output_mode_o, 2'h2)
         pulse(OU);
         @(negedge clock_i);
         `CHK(output_mode_o, 2'h0)
         @(posedge clock_i);
      end
      finish_test();
   end
endmodule
